// File: write_multiple_cmd_handler.sv
// device-side multi-sector PIO write command handler
// Overview of operation
// - head field is head or LBA 27:24
// - sector count returns untransferred sectors for 28-bit; 48-bit reads zero
// - LBA low returns last sector number
// - mid/high return last cylinder or LBA
// - head field returns last head/LBA 27:24
// - opcode 39h is 48-bit write multiple
// - one interrupt per multiple block
// - data register moves 16-bit words
// - count: current low, previous high byte
// - zero count means 65536 sectors
// - LBA built from current and previous bytes
// - failing LBA read back by HOB select
// - opcode CEh is forced-unit-access variant
// - forced variant commits media before status
// - media error stops at failing sector, reported as IDNF
`include "wrmult_params.svh"
module write_multiple_cmd_handler
  import wrmult_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire reg_req_type reg_req,
  output logic [15:0]      reg_rdata,
  output media_req_type    media_req,
  input  wire logic        media_done_raw,
  input  wire logic        media_err_raw,
  output logic             irq
);
  localparam int COMMIT_CYCLES = `COMMIT_CYC;

  // 48-bit parameter bytes, current and previous
  logic [7:0]  sc_cur_r, sc_prv_r, lo_cur_r, lo_prv_r;
  logic [7:0]  mid_cur_r, mid_prv_r, hi_cur_r, hi_prv_r;
  logic [7:0]  device_r, devctl_r, blksize_r;
  logic [7:0]  err_r, irq_stat_r, irq_en_r;
  logic        cache_en_r, ext_r, fua_r;
  logic [47:0] lba_r;
  logic [16:0] remain_r;
  logic [8:0]  word_cnt_r;
  logic [7:0]  blk_cnt_r;
  logic [11:0] commit_cnt_r;
  logic        done_s1_r, done_s2_r, merr_s1_r, merr_s2_r;
  phase_type   phase_r;
  logic        drq, bsy, err_bit;
  logic        data_wr, cmd_wr, cmd_ok;
  logic [7:0]  cmd;
  logic        hob;

  function automatic logic [7:0] tf_byte(input logic [47:0] v,
                                         input logic [2:0] idx);
    tf_byte = v[idx*8 +: 8];
  endfunction : tf_byte

  assign cmd     = reg_req.wdata[7:0];
  assign cmd_wr  = reg_req.wr && reg_req.addr == `TF_CMDSTAT;
  assign data_wr = reg_req.wr && reg_req.addr == `TF_DATA;
  assign cmd_ok  = cmd == `CMD_WRMULT || cmd == `CMD_WRMULT48 ||
                   cmd == `CMD_WRFUA48;
  assign drq     = phase_r == ST_DRQ;
  assign bsy     = phase_r == ST_WRITE || phase_r == ST_COMMIT;
  assign err_bit = err_r != 8'h00;
  assign hob     = devctl_r[`CTL_HOB_BIT];

  // media handshake crosses in from the drive electronics
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      done_s1_r <= 1'b0;
      done_s2_r <= 1'b0;
      merr_s1_r <= 1'b0;
      merr_s2_r <= 1'b0;
    end else begin
      done_s1_r <= media_done_raw;
      done_s2_r <= done_s1_r;
      merr_s1_r <= media_err_raw;
      merr_s2_r <= merr_s1_r;
    end
  end

  // parameter byte shifting: each count or LBA write while idle or done pushes current into previous
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sc_cur_r  <= 8'h00;
      sc_prv_r  <= 8'h00;
      lo_cur_r  <= 8'h00;
      lo_prv_r  <= 8'h00;
      mid_cur_r <= 8'h00;
      mid_prv_r <= 8'h00;
      hi_cur_r  <= 8'h00;
      hi_prv_r  <= 8'h00;
      device_r  <= 8'h00;
      devctl_r  <= 8'h00;
      blksize_r <= `BLKSIZE_RST;
      cache_en_r <= 1'b0;
      irq_en_r  <= 8'h00;
    // a finished command leaves the sequencer in done, which is idle too
    end else if (reg_req.wr &&
                 (phase_r == ST_IDLE || phase_r == ST_DONE)) begin
      unique case (reg_req.addr)
        `TF_SECCNT: begin
          sc_prv_r <= sc_cur_r;
          sc_cur_r <= reg_req.wdata[7:0];
        end
        `TF_LBALO: begin
          lo_prv_r <= lo_cur_r;
          lo_cur_r <= reg_req.wdata[7:0];
        end
        `TF_LBAMID: begin
          mid_prv_r <= mid_cur_r;
          mid_cur_r <= reg_req.wdata[7:0];
        end
        `TF_LBAHI: begin
          hi_prv_r <= hi_cur_r;
          hi_cur_r <= reg_req.wdata[7:0];
        end
        `TF_DEVICE:  device_r   <= reg_req.wdata[7:0];
        `TF_DEVCTL:  devctl_r   <= reg_req.wdata[7:0];
        `TF_BLKSIZE: blksize_r  <= reg_req.wdata[7:0];
        `TF_IRQ_EN:  irq_en_r   <= reg_req.wdata[7:0];
        `TF_CACHE:   cache_en_r <= reg_req.wdata[0];
        default: ;
      endcase
    end else if (reg_req.wr && reg_req.addr == `TF_DEVCTL) begin
      devctl_r <= reg_req.wdata[7:0];
    end else if (reg_req.wr && reg_req.addr == `TF_IRQ_EN) begin
      irq_en_r <= reg_req.wdata[7:0];
    end
  end

  // command sequencer
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      phase_r      <= ST_IDLE;
      ext_r        <= 1'b0;
      fua_r        <= 1'b0;
      lba_r        <= 48'h0;
      remain_r     <= 17'h0;
      word_cnt_r   <= 9'h0;
      blk_cnt_r    <= 8'h00;
      commit_cnt_r <= 12'h0;
      err_r        <= 8'h00;
      media_req    <= '0;
    end else begin
      media_req.wr <= 1'b0;
      unique case (phase_r)
        ST_IDLE, ST_DONE: begin
          if (cmd_wr && cmd_ok) begin
            ext_r      <= cmd != `CMD_WRMULT;
            fua_r      <= cmd == `CMD_WRFUA48;
            err_r      <= 8'h00;
            word_cnt_r <= 9'h0;
            blk_cnt_r  <= 8'h00;
            if (cmd != `CMD_WRMULT) begin
              lba_r <= {hi_prv_r, mid_prv_r, lo_prv_r,
                        hi_cur_r, mid_cur_r, lo_cur_r};
              remain_r <= {sc_prv_r, sc_cur_r} == 16'h0000 ?
                          17'h10000 : {1'b0, sc_prv_r, sc_cur_r};
            end else begin
              // head field doubles as LBA 27:24 in LBA mode
              lba_r <= {20'h0, device_r[3:0], hi_cur_r,
                        mid_cur_r, lo_cur_r};
              remain_r <= sc_cur_r == 8'h00 ?
                          17'h100 : {9'h0, sc_cur_r};
            end
            phase_r <= ST_DRQ;
          end else if (cmd_wr) begin
            err_r   <= 8'h01 << `ERR_ABRT_BIT;
            phase_r <= ST_DONE;
          end
        end
        ST_DRQ: begin
          if (data_wr) begin
            if (word_cnt_r == `WORDS_PER_SEC - 9'h1) begin
              word_cnt_r      <= 9'h0;
              media_req.lba   <= lba_r;
              media_req.fua   <= fua_r;
              media_req.wr    <= 1'b1;
              phase_r         <= ST_WRITE;
            end else begin
              word_cnt_r <= word_cnt_r + 9'h1;
            end
          end
        end
        ST_WRITE: begin
          if (merr_s2_r) begin
            // failing sector stays addressed, count keeps it
            err_r   <= 8'h01 << `ERR_IDNF_BIT;
            phase_r <= ST_DONE;
          end else if (done_s2_r) begin
            remain_r <= remain_r - 17'h1;
            if (remain_r == 17'h1) begin
              // status waits for media commit when forced or uncached
              commit_cnt_r <= 12'(COMMIT_CYCLES);
              phase_r <= (fua_r || !cache_en_r) ? ST_COMMIT : ST_DONE;
            end else begin
              lba_r     <= lba_r + 48'h1;
              blk_cnt_r <= blk_cnt_r + 8'h1;
              phase_r   <= ST_DRQ;
              if (blk_cnt_r + 8'h1 == blksize_r)
                blk_cnt_r <= 8'h00;
            end
          end
        end
        ST_COMMIT: begin
          commit_cnt_r <= commit_cnt_r - 12'h1;
          if (commit_cnt_r == 12'h1)
            phase_r <= ST_DONE;
        end
        default: phase_r <= ST_IDLE;
      endcase
    end
  end

  // sticky events: bit0 block request, bit1 command done
  logic blk_ev, done_ev;
  assign blk_ev = (phase_r == ST_IDLE || phase_r == ST_DONE) &&
                  cmd_wr && cmd_ok ||
                  phase_r == ST_WRITE && done_s2_r && !merr_s2_r &&
                  remain_r != 17'h1 && blk_cnt_r + 8'h1 == blksize_r;
  assign done_ev = phase_r == ST_COMMIT && commit_cnt_r == 12'h1 ||
                   phase_r == ST_WRITE && merr_s2_r ||
                   phase_r == ST_WRITE && done_s2_r && remain_r == 17'h1 &&
                   !fua_r && cache_en_r ||
                   (phase_r == ST_IDLE || phase_r == ST_DONE) &&
                   cmd_wr && !cmd_ok;

  // a new event wins over a clear in the same cycle
  logic [7:0] irq_stat_nxt;
  assign irq_stat_nxt = (irq_stat_r &
                         ~((reg_req.wr && reg_req.addr == `TF_IRQ_CLR) ?
                           reg_req.wdata[7:0] : 8'h00)) |
                        {6'h0, done_ev, blk_ev};

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_stat_r <= 8'h00;
      irq        <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      // follows the next status so a clear drops the line at once
      irq        <= |(irq_stat_nxt & irq_en_r);
    end
  end

  // read-back mux: HOB picks upper bytes of the 48-bit address
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else if (reg_req.rd) begin
      unique case (reg_req.addr)
        `TF_ERROR:  reg_rdata <= {8'h00, err_r};
        `TF_SECCNT: reg_rdata <= ext_r ? 16'h0000 :
                                 {8'h00, remain_r[7:0]};
        `TF_LBALO:  reg_rdata <= {8'h00,
                      tf_byte(lba_r, (ext_r && hob) ? 3'd3 : 3'd0)};
        `TF_LBAMID: reg_rdata <= {8'h00,
                      tf_byte(lba_r, (ext_r && hob) ? 3'd4 : 3'd1)};
        `TF_LBAHI:  reg_rdata <= {8'h00,
                      tf_byte(lba_r, (ext_r && hob) ? 3'd5 : 3'd2)};
        `TF_DEVICE: reg_rdata <= {8'h00, device_r[7:4],
                      ext_r ? device_r[3:0] : lba_r[27:24]};
        `TF_CMDSTAT: reg_rdata <= {8'h00, bsy, !bsy, 1'b0, 1'b1, drq,
                      2'b00, err_bit};
        `TF_DEVCTL:  reg_rdata <= {8'h00, devctl_r};
        `TF_BLKSIZE: reg_rdata <= {8'h00, blksize_r};
        `TF_IRQ_STAT: reg_rdata <= {8'h00, irq_stat_r};
        `TF_IRQ_EN:   reg_rdata <= {8'h00, irq_en_r};
        `TF_CACHE:    reg_rdata <= {15'h0, cache_en_r};
        default:      reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule : write_multiple_cmd_handler

// File: write_multiple_cmd_handler_asserts.sv
// checker for the multi-sector write command handler
module wrmult_asserts
  import wrmult_pkg::*;
(
  input wire logic          sys_clk,
  input wire logic          reset,
  input wire reg_req_type   reg_req,
  input wire logic [15:0]   reg_rdata,
  input wire media_req_type media_req,
  input wire logic          media_done_raw,
  input wire logic          media_err_raw,
  input wire logic          irq
);
  logic [7:0]  cmd_r, en_r;
  logic [8:0]  wcnt_r;
  logic [47:0] lba_r, nsec_r;
  logic        err_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // shadow of the host-side parameter loads, previous byte shifted up
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      en_r <= 8'h00;
      err_r <= 1'b0;
    end else if (reg_req.wr && reg_req.addr == 4'hb) begin
      en_r <= reg_req.wdata[7:0];
    end else if (reg_req.wr && reg_req.addr == 4'h7) begin
      cmd_r <= reg_req.wdata[7:0];
      wcnt_r <= 9'h000;
      nsec_r <= 48'h0;
      err_r <= 1'b0;
    end else if (reg_req.wr && reg_req.addr == 4'h0) begin
      wcnt_r <= wcnt_r + 9'h001;
    end else if (reg_req.wr && reg_req.addr inside {[4'h3:4'h5]}) begin
      lba_r[8 * (reg_req.addr - 4'h3) + 24 +: 8] <=
        lba_r[8 * (reg_req.addr - 4'h3) +: 8];
      lba_r[8 * (reg_req.addr - 4'h3) +: 8] <= reg_req.wdata[7:0];
    end else if (media_req.wr) begin
      wcnt_r <= 9'h000;
      nsec_r <= nsec_r + 48'h1;
    end
    if (!reset && media_err_raw) err_r <= 1'b1;
  end
  property p_rd_idle;
    !$past(reg_req.rd) |-> reg_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray rdata");
  property p_words;
    media_req.wr |-> wcnt_r == 9'h100;
  endproperty
  a_words: assert property (p_words) else $error("word count");
  property p_pulse;
    media_req.wr |=> !media_req.wr;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long pulse");
  property p_lba;
    media_req.wr && cmd_r != 8'hc5 |-> media_req.lba == lba_r + nsec_r;
  endproperty
  a_lba: assert property (p_lba) else $error("sector lba");
  property p_fua;
    media_req.wr && cmd_r == 8'hce |-> media_req.fua;
  endproperty
  a_fua: assert property (p_fua) else $error("fua flag");
  property p_op;
    media_req.wr |-> cmd_r inside {8'hc5, 8'h39, 8'hce};
  endproperty
  a_op: assert property (p_op) else $error("bad opcode ran");
  property p_irq_en;
    irq |-> $past(en_r[1:0]) != 2'b00;
  endproperty
  a_irq_en: assert property (p_irq_en) else $error("masked irq");
  property p_stop;
    media_req.wr |-> !err_r;
  endproperty
  a_stop: assert property (p_stop) else $error("write after err");
endmodule : wrmult_asserts

bind write_multiple_cmd_handler wrmult_asserts u_chk (
  .sys_clk(sys_clk), .reset(reset), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .media_req(media_req),
  .media_done_raw(media_done_raw), .media_err_raw(media_err_raw),
  .irq(irq));

// File: write_multiple_cmd_handler_tb_top.sv
// self-checking bench for the multi-sector write command handler
module write_multiple_cmd_handler_tb_top
  import wrmult_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          sys_clk, reset, irq, m_done, m_err;
  logic [7:0]    err_at;
  logic [3:0]    dly;
  reg_req_type   req;
  media_req_type mreq;
  logic [15:0]   rdata, d;
  logic [47:0]   lba, base, exp_q[$];
  int            failures, n_compared, i, j, k;
  write_multiple_cmd_handler dut (.sys_clk(sys_clk), .reset(reset),
    .reg_req(req), .reg_rdata(rdata), .media_req(mreq),
    .media_done_raw(m_done), .media_err_raw(m_err), .irq(irq));
  wrmult_media m (.sys_clk(sys_clk), .media_req(mreq), .err_at(err_at),
    .dly(dly), .done(m_done), .err(m_err));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    req <= '{a, v, 1'b1, 1'b0};
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge sys_clk);
    req.rd <= 1'b0;
    @(negedge sys_clk);
    d = rdata;
  endtask : rd
  task automatic poll(input logic [7:0] msk, input logic [7:0] v);
    for (j = 0; j < 3000; j++) begin
      rd(4'h7);
      if ((d[7:0] & msk) === v) return;
    end
    failures++;
    $display("unexpected at %0t: status wait ran out", $time);
    finish_test();
  endtask : poll
  task automatic run(input logic [7:0] op, input int cnt, input int fail,
                     input logic [7:0] experr);
    lba = 48'({$urandom, $urandom});
    // the 28-bit command uses current bytes and the head nibble only
    base = (op == 8'hc5) ? {20'h0, lba[27:0]} : lba;
    exp_q = {};
    m.got_q = {};
    m.n = 0;
    err_at <= fail[7:0];
    dly <= 4'($urandom_range(1, 9));
    wr(4'h2, 16'(cnt >> 8));
    wr(4'h2, 16'(cnt & 8'hff));
    for (i = 0; i < 3; i++) begin
      wr(4'(3 + i), 16'(lba[8 * i + 24 +: 8]));
      wr(4'(3 + i), 16'(lba[8 * i +: 8]));
    end
    wr(4'h6, 16'({4'h4, lba[27:24]}));
    wr(4'hb, 16'h0003);
    wr(4'hd, 16'h0001);
    wr(4'h7, 16'(op));
    for (i = 0; i < cnt && i <= fail; i++) begin
      exp_q.push_back(base + 48'(i));
      poll(8'h08, 8'h08);
      repeat (256) wr(4'h0, 16'($urandom));
    end
    if (fail >= cnt && cnt > 0) begin
      // with caching on only the forced variant is still busy here
      for (j = 0; j < 40 && m_done !== 1'b1; j++)
        @(posedge sys_clk);
      repeat (4) @(posedge sys_clk);
      rd(4'h7);
      chk(d[7], op == 8'hce);
    end
    poll(8'h88, 8'h00);
    chk(d[0], experr != 8'h00);
    chk(m.got_q.size(), exp_q.size());
    foreach (exp_q[k]) chk(m.got_q[k], exp_q[k]);
    rd(4'h1);
    chk(d[7:0], experr);
    if (op == 8'hc5) begin
      base = base + 48'(cnt - 1);
      rd(4'h2);
      chk(d, 16'h0000);
      for (k = 0; k < 3; k++) begin
        rd(4'(3 + k));
        chk(d, 16'(base[8 * k +: 8]));
      end
      rd(4'h6);
      chk(d, {12'h004, base[27:24]});
    end
    if (fail < cnt) begin
      base = base + 48'(fail);
      for (k = 0; k < 6; k++) begin
        if (k % 3 == 0) wr(4'h8, k ? 16'h0080 : 16'h0000);
        rd(4'(3 + k % 3));
        chk(d[7:0], base[8 * k +: 8]);
      end
      wr(4'h8, 16'h0000);
    end
    chk(irq, 1'b1);
    rd(4'ha);
    chk(d[1], 1'b1);
    wr(4'hc, 16'h0003);
    rd(4'ha);
    chk({irq, d[1:0]}, 3'b000);
    $display("test %h done", op);
  endtask : run
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  initial begin
    void'($urandom(32'h04e6));
    failures = 0;
    n_compared = 0;
    reset = 1'b1;
    req = '0;
    err_at = 8'hff;
    dly = 4'h1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    run(8'h39, 2, 99, 8'h00);
    run(8'hce, 1, 99, 8'h00);
    run(8'h39, 3, 1, 8'h10);
    run(8'hc5, 2, 99, 8'h00);
    run(8'h55, 0, 99, 8'h04);
    finish_test();
  end
endmodule : write_multiple_cmd_handler_tb_top

// File: wrmult_media.sv
// media partner: answers each sector write with a done level
module wrmult_media
  import wrmult_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire media_req_type media_req,
  input  wire logic [7:0]    err_at,
  input  wire logic [3:0]    dly,
  output logic               done,
  output logic               err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [47:0] got_q[$];
  int          n;
  initial begin
    done = 1'b0;
    err = 1'b0;
    n = 0;
    forever begin
      @(posedge sys_clk);
      if (media_req.wr) begin
        got_q.push_back(media_req.lba);
        repeat (dly) @(posedge sys_clk);
        done <= 1'b1;
        err <= (n == err_at);
        n++;
        // three cycles covers the two-flop synchroniser
        repeat (3) @(posedge sys_clk);
        done <= 1'b0;
        err <= 1'b0;
      end
    end
  end
endmodule : wrmult_media

// File: wrmult_params.svh
// constants for the multi-sector write command handler
`ifndef WRMULT_PARAMS_SVH
`define WRMULT_PARAMS_SVH
`define TF_DATA       4'h0
`define TF_ERROR      4'h1
`define TF_SECCNT     4'h2
`define TF_LBALO      4'h3
`define TF_LBAMID     4'h4
`define TF_LBAHI      4'h5
`define TF_DEVICE     4'h6
`define TF_CMDSTAT    4'h7
`define TF_DEVCTL     4'h8
`define TF_BLKSIZE    4'h9
`define TF_IRQ_STAT   4'ha
`define TF_IRQ_EN     4'hb
`define TF_IRQ_CLR    4'hc
`define TF_CACHE      4'hd
`define CMD_WRMULT    8'hc5
`define CMD_WRMULT48  8'h39
`define CMD_WRFUA48   8'hce
`define DEV_LBA_BIT   6
`define CTL_HOB_BIT   7
`define ERR_IDNF_BIT  4
`define ERR_ABRT_BIT  2
`define ST_RDY_BIT    6
`define ST_DRQ_BIT    3
`define ST_ERR_BIT    0
`define ST_BSY_BIT    7
`define WORDS_PER_SEC 9'h100
`define BLKSIZE_RST   8'h01
`define COMMIT_NS     2000
`define COMMIT_CYC    ((`COMMIT_NS + 39) / 40)
`endif

// File: wrmult_pkg.sv
// types for the multi-sector write command handler
package wrmult_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_type;

  typedef struct packed {
    logic [47:0] lba;
    logic        wr;
    logic        fua;
  } media_req_type;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_DRQ    = 3'b001,
    ST_WRITE  = 3'b011,
    ST_COMMIT = 3'b010,
    ST_DONE   = 3'b110
  } phase_type;
endpackage : wrmult_pkg
